// ==== design/irq_pkg.sv ====
// Constants shared by the interrupt flag and enable logic.
package irq_pkg;
    localparam int NUM_SRC = 7;
    localparam logic [3:0] REG_FLAG = 4'hD;
    localparam logic [3:0] REG_ENABLE = 4'hE;
    localparam int SUMMARY_BIT = 7;
    localparam int SET_CLEAR_BIT = 7;
    localparam logic [6:0] FLAG_RESET = 7'h00;
    localparam logic [6:0] ENABLE_RESET = 7'h00;
    localparam logic [7:0] DATA_IDLE = 8'h00;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } access_t;
endpackage

// ==== design/enable_update.sv ====
`timescale 1ns/1ns
// Set or clear update of the enable mask from one written data byte.
module enable_update #(
    parameter int WIDTH = 7
) (
    // Current mask and written data
    input wire logic [WIDTH-1:0] mask_cur,
    input wire logic [WIDTH-1:0] sel_bits,
    input wire logic set_mode,
    // Updated mask
    output logic [WIDTH-1:0] mask_new
);
    initial begin
        if (WIDTH < 1 || WIDTH > 7) begin
            $error("enable_update: WIDTH must be 1 to 7");
        end
    end

    always_comb begin
        if (set_mode) begin
            mask_new = mask_cur | sel_bits;
        end else begin
            mask_new = mask_cur & ~sel_bits;
        end
    end
endmodule

// ==== design/interrupt_flag_enable_logic.sv ====
`timescale 1ns/1ns
// Interrupt flag and enable registers with wire-OR interrupt request.
// What this block does
// - Request when any flag and enable match.
// - Flag bit 7 is not a clearable flag.
// - Summary clears only when nothing enabled pends.
// - Enable write, bit7 low: ones clear.
// - Enable write, bit7 high: ones set.
// - Zero data bits leave enables unchanged.
// - Enable read gives mask, bit 7 one.
// - Writing one to flag clears it.
// - Flag bit 7 mirrors request state.
// - Request is active low, open drain.
module interrupt_flag_enable_logic #(
    parameter int NUM_SRC = irq_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic chip_sel,
    input wire logic write_en,
    input wire logic [3:0] reg_sel,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Flag sources, one-cycle set pulses
    input wire logic [NUM_SRC-1:0] flag_set,
    // Interrupt request pin
    output logic irq_n_out,
    output logic irq_n_oe
);
    logic [NUM_SRC-1:0] flag_r;
    logic [NUM_SRC-1:0] flag_nxt;
    logic [NUM_SRC-1:0] enable_r;
    logic [NUM_SRC-1:0] enable_nxt;
    logic [NUM_SRC-1:0] enable_upd;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic pending;
    irq_pkg::access_t acc;
    logic wr_flag;
    logic wr_enable;
    logic rd_flag;
    logic rd_enable;
    logic [NUM_SRC-1:0] flag_cleared;

    // True when the access of this cycle is of the wanted kind and hits the given register.
    function automatic logic access_hit(input irq_pkg::access_t kind_now,
        input irq_pkg::access_t kind_want, input logic [3:0] sel, input logic [3:0] code);
        access_hit = (kind_now == kind_want) && (sel == code);
    endfunction

    initial begin
        if (NUM_SRC != irq_pkg::NUM_SRC) begin
            $error("interrupt_flag_enable_logic: NUM_SRC must be 7");
        end
        if (irq_pkg::SUMMARY_BIT != NUM_SRC || irq_pkg::SET_CLEAR_BIT != NUM_SRC) begin
            $error("interrupt_flag_enable_logic: bit 7 must sit just above the sources");
        end
    end

    always_comb begin
        if (!chip_sel) begin
            acc = irq_pkg::ACC_IDLE;
        end else if (write_en) begin
            acc = irq_pkg::ACC_WRITE;
        end else begin
            acc = irq_pkg::ACC_READ;
        end
    end

    assign pending = |(flag_r & enable_r);

    // Register decode; any other select is ignored on write and reads as zero.
    assign wr_flag = access_hit(acc, irq_pkg::ACC_WRITE, reg_sel, irq_pkg::REG_FLAG);
    assign wr_enable = access_hit(acc, irq_pkg::ACC_WRITE, reg_sel, irq_pkg::REG_ENABLE);
    assign rd_flag = access_hit(acc, irq_pkg::ACC_READ, reg_sel, irq_pkg::REG_FLAG);
    assign rd_enable = access_hit(acc, irq_pkg::ACC_READ, reg_sel, irq_pkg::REG_ENABLE);

    enable_update #(.WIDTH(NUM_SRC)) u_enable_update (
        .mask_cur(enable_r),
        .sel_bits(wr_data[NUM_SRC-1:0]),
        .set_mode(wr_data[irq_pkg::SET_CLEAR_BIT]),
        .mask_new(enable_upd)
    );

    // Flag group. A new event wins over a clear in the same cycle.
    always_comb begin
        flag_cleared = flag_r;
        if (wr_flag) begin
            flag_cleared = flag_r & ~wr_data[NUM_SRC-1:0];
        end
        flag_nxt = flag_cleared | flag_set;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_r <= irq_pkg::FLAG_RESET;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Enable group. Only a write to the enable register moves the mask.
    always_comb begin
        enable_nxt = enable_r;
        if (wr_enable) begin
            enable_nxt = enable_upd;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_r <= irq_pkg::ENABLE_RESET;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // Read group. The byte stands for the one cycle after the read is taken.
    always_comb begin
        rd_data_nxt = irq_pkg::DATA_IDLE;
        if (rd_flag) begin
            rd_data_nxt = {pending, flag_r};
        end else if (rd_enable) begin
            rd_data_nxt = {1'b1, enable_r};
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_r <= irq_pkg::DATA_IDLE;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    // Pin is only ever pulled low; released otherwise.
    assign irq_n_out = 1'b0;
    assign irq_n_oe = pending;

    // Request pin, summary bit and flag read.
    chk_irq_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|(flag_set & enable_r)
        && !(chip_sel && write_en && reg_sel == irq_pkg::REG_ENABLE))
        |=> irq_n_oe)
        else $error("enabled event did not drive the request");

    chk_irq_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && write_en && reg_sel == irq_pkg::REG_FLAG && flag_set == '0
        && (flag_r & enable_r & ~wr_data[NUM_SRC-1:0]) == '0)
        |=> !irq_n_oe)
        else $error("request still driven after pending flags cleared");

    chk_summary_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(irq_n_oe)
        |-> ($past(wr_flag) || $past(wr_enable)))
        else $error("summary dropped without a clear or disable write");

    chk_summary_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && !write_en && reg_sel == irq_pkg::REG_FLAG)
        |=> rd_data[irq_pkg::SUMMARY_BIT] == $past(irq_n_oe))
        else $error("summary bit differs from request");

    chk_flag_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && !write_en && reg_sel == irq_pkg::REG_FLAG)
        |=> rd_data[NUM_SRC-1:0] == $past(flag_r))
        else $error("flag read does not show the flags");

    // Flag register.
    chk_flag_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && write_en && reg_sel == irq_pkg::REG_FLAG && flag_set == '0)
        |=> flag_r == ($past(flag_r) & ~$past(wr_data[NUM_SRC-1:0])))
        else $error("flag write did not clear ones");

    chk_flag_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(chip_sel && write_en && reg_sel == irq_pkg::REG_FLAG)
        |=> flag_r == ($past(flag_r) | $past(flag_set)))
        else $error("flags changed without a write or event");

    chk_top_not_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && write_en && reg_sel == irq_pkg::REG_FLAG
        && wr_data[NUM_SRC-1:0] == '0 && flag_set == '0)
        |=> $stable(flag_r))
        else $error("writing only bit 7 changed the flags");

    chk_set_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (flag_set != '0)
        |=> (flag_r & $past(flag_set)) == $past(flag_set))
        else $error("set event lost");

    // Enable register.
    chk_enable_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && write_en && reg_sel == irq_pkg::REG_ENABLE
        && wr_data[irq_pkg::SET_CLEAR_BIT])
        |=> enable_r == ($past(enable_r) | $past(wr_data[NUM_SRC-1:0])))
        else $error("enable set write wrong");

    chk_enable_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && write_en && reg_sel == irq_pkg::REG_ENABLE
        && !wr_data[irq_pkg::SET_CLEAR_BIT])
        |=> enable_r == ($past(enable_r) & ~$past(wr_data[NUM_SRC-1:0])))
        else $error("enable clear write wrong");

    chk_enable_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(chip_sel && write_en && reg_sel == irq_pkg::REG_ENABLE)
        |=> $stable(enable_r))
        else $error("enable changed without write");

    chk_enable_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_sel && !write_en && reg_sel == irq_pkg::REG_ENABLE)
        |=> rd_data == {1'b1, $past(enable_r)})
        else $error("enable read wrong");

    chk_read_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(rd_flag || rd_enable)
        |=> rd_data == irq_pkg::DATA_IDLE)
        else $error("read data not idle without a register read");

    // Reset.
    chk_reset_clear: assert property (@(posedge ref_clk)
        $fell(sys_rst)
        |-> (flag_r == irq_pkg::FLAG_RESET && enable_r == irq_pkg::ENABLE_RESET && !irq_n_oe))
        else $error("state not cleared by reset");
endmodule

// ==== tb/host_irq_line.sv ====
`timescale 1ns/1ns
// Host side of the shared request line, with its pull-up.
module host_irq_line (
    // Pin from the block
    input wire logic irq_n_out,
    input wire logic irq_n_oe,
    // Level the host sees
    output logic irq_line
);
    assign irq_line = irq_n_oe ? irq_n_out : 1'b1;
endmodule

// ==== tb/interrupt_flag_enable_logic_bench.sv ====
`timescale 1ns/1ns
// Self-checking bench for the interrupt flag and enable logic.
module interrupt_flag_enable_logic_bench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_sel = 1'b0;
    logic write_en = 1'b0;
    logic [3:0] reg_sel = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic [6:0] flag_set = 7'h00;
    logic [7:0] rd_data;
    logic irq_n_out;
    logic irq_n_oe;
    logic irq_line;
    logic rd_seen = 1'b0;
    logic [6:0] fl = 7'h00;
    logic [6:0] en = 7'h00;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;
    always #25 ref_clk = ~ref_clk;
    interrupt_flag_enable_logic uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .chip_sel(chip_sel), .write_en(write_en), .reg_sel(reg_sel), .wr_data(wr_data),
        .rd_data(rd_data), .flag_set(flag_set), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    host_irq_line host (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        total_checks++;
        if (seen !== expd) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, expd);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One bus cycle with optional source events; a read notes its expected byte.
    task automatic acc(input logic we, input logic [3:0] sel, input logic [7:0] d,
        input logic [6:0] fs);
        @(negedge ref_clk);
        flag_set = fs;
        chip_sel = 1'b1;
        write_en = we;
        reg_sel = sel;
        wr_data = d;
        if (!we) begin
            exp_q.push_back(sel == irq_pkg::REG_ENABLE ? {1'b1, en} :
                sel == irq_pkg::REG_FLAG ? {|(fl & en), fl} : 8'h00);
        end
        @(posedge ref_clk);
        if (we && sel == irq_pkg::REG_FLAG) fl = fl & ~d[6:0];
        if (we && sel == irq_pkg::REG_ENABLE) en = d[7] ? (en | d[6:0]) : (en & ~d[6:0]);
        fl = fl | fs;
    endtask
    always @(posedge ref_clk) rd_seen <= chip_sel && !write_en;
    always @(negedge ref_clk) begin
        if (rd_seen) check(rd_data, exp_q.pop_front());
        if (!sys_rst) check({7'h00, irq_line}, {7'h00, ~|(fl & en)});
    end
    initial begin
        void'($urandom(38518));
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        acc(1'b0, irq_pkg::REG_FLAG, 8'h00, 7'h00);
        acc(1'b0, irq_pkg::REG_ENABLE, 8'h00, 7'h00);
        repeat (60) begin
            @(negedge ref_clk);
            chip_sel = 1'b0;
            flag_set = 7'($urandom);
            @(posedge ref_clk);
            fl = fl | flag_set;
            acc(1'b1, irq_pkg::REG_ENABLE, 8'($urandom), 7'h00);
            acc(1'b0, irq_pkg::REG_ENABLE, 8'h00, 7'h00);
            acc(1'b0, irq_pkg::REG_FLAG, 8'h00, 7'h00);
            acc(1'b1, irq_pkg::REG_FLAG, 8'($urandom), 7'h00);
            acc(1'b0, irq_pkg::REG_FLAG, 8'h00, 7'h00);
            acc(1'b1, irq_pkg::REG_FLAG, 8'($urandom), 7'($urandom));
            acc(1'b1, irq_pkg::REG_FLAG, 8'h80, 7'h00);
            acc(1'b0, irq_pkg::REG_FLAG, 8'h00, 7'h00);
            acc(1'b1, 4'($urandom_range(12)), 8'($urandom), 7'h00);
            acc(1'b0, 4'($urandom_range(12)), 8'h00, 7'h00);
        end
        @(negedge ref_clk);
        chip_sel = 1'b0;
        // Second reset with live state, then both registers must read cleared.
        @(negedge ref_clk);
        sys_rst = 1'b1;
        fl = 7'h00;
        en = 7'h00;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        acc(1'b0, irq_pkg::REG_FLAG, 8'h00, 7'h00);
        acc(1'b0, irq_pkg::REG_ENABLE, 8'h00, 7'h00);
        @(negedge ref_clk);
        chip_sel = 1'b0;
        repeat (2) @(negedge ref_clk);
        conclude();
    end
endmodule
